// file: hw/sssc_consts.svh
// Constants for the sync SRAM sleep and access sequencer
`ifndef SSSC_CONSTS_SVH
`define SSSC_CONSTS_SVH
`define SSSC_CLK_PERIOD_PS   25000
`define SSSC_EXIT_CYCLES     2
`define SSSC_EXIT_TIME_PS    (`SSSC_EXIT_CYCLES * `SSSC_CLK_PERIOD_PS)
`define SSSC_EXIT_CNT        ((`SSSC_EXIT_TIME_PS + `SSSC_CLK_PERIOD_PS - 1) / `SSSC_CLK_PERIOD_PS)
`define SSSC_ADDR_W          16
`define SSSC_DATA_W          32
`define SSSC_LANES           4
`endif

// file: hw/sssc_ctrl.sv
// Sleep handling, select decode and write control of a 64K x 32 pipelined sync SRAM
// Notes on behaviour
// - After a write begins, output drive control is ignored for that write.
// - Writes in pre-sleep or recovery window may corrupt the array.
// - Read data right after sleep request is not guaranteed valid.
// - Entering sleep deselects the device.
// - In sleep, device stays unselected and performs no access.
// - Combined strobe low when either strobe low, high only when both high.
// - Non-burst mode uses a fresh external address every access.
// - Write when any lane write plus qualifier low, or global write low.
// - Output drive control passes the two-stage synchroniser, drives no sooner than two cycles after it falls.
`timescale 1ns/1ps
`include "sssc_consts.svh"
module sssc_ctrl
  import sssc_pkg::*;
#(
  parameter int AW   = `SSSC_ADDR_W,
  parameter int DW   = `SSSC_DATA_W,
  parameter int NL   = `SSSC_LANES,
  parameter int EXIT = `SSSC_EXIT_CNT
) (
  input  wire logic          ref_clk_i,
  input  wire logic          reset_i,
  input  wire logic          sleep_request_i,
  input  wire logic          processor_addr_strobe_n_i,
  input  wire logic          controller_addr_strobe_n_i,
  input  wire logic          burst_advance_n_i,
  input  wire logic          chip_sel_first_n_i,
  input  wire logic          chip_sel_second_i,
  input  wire logic          chip_sel_third_n_i,
  input  wire logic          burst_order_select_i,
  input  wire logic [NL-1:0] byte_lane_write_n_i,
  input  wire logic          write_qualifier_n_i,
  input  wire logic          global_write_n_i,
  input  wire logic          out_drive_n_i,
  input  wire logic [AW-1:0] addr_i,
  input  wire logic [DW-1:0] dq_i,
  output logic      [DW-1:0] dq_o,
  output logic               dq_oe_o,
  output logic               asleep_o,
  output logic               selected_o,
  output logic               unsafe_window_o
);
  localparam int SW = 13 + NL;
  localparam int CW = $clog2(EXIT + 1);

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  logic [SW-1:0] sync_w;
  logic          slp_s;
  logic          processor_addr_strobe_n_n_s;
  logic          controller_addr_strobe_n_n_s;
  logic          adv_n_s;
  logic          cs1_n_s;
  logic          cs2_s;
  logic          cs3_n_s;
  logic          order_s;
  logic [NL-1:0] lane_n_s;
  logic          wq_n_s;
  logic          gw_n_s;
  logic          oe_n_s;
  logic [1:0]    spare_s;

  sssc_sync #(.W(SW)) u_sync (
    .ref_clk_i (ref_clk_i),
    .reset_i   (reset_i),
    .async_i   ({sleep_request_i, processor_addr_strobe_n_i, controller_addr_strobe_n_i,
                 burst_advance_n_i, chip_sel_first_n_i, chip_sel_second_i, chip_sel_third_n_i,
                 burst_order_select_i, byte_lane_write_n_i, write_qualifier_n_i,
                 global_write_n_i, out_drive_n_i, 2'b00}),
    .sync_o    (sync_w)
  );

  assign {slp_s, processor_addr_strobe_n_n_s, controller_addr_strobe_n_n_s, adv_n_s, cs1_n_s, cs2_s, cs3_n_s, order_s,
          lane_n_s, wq_n_s, gw_n_s, oe_n_s, spare_s} = sync_w;

  // Address and write data ride the same two stages as the controls
  logic [AW+DW-1:0] data_sync_w;
  logic [AW-1:0]    addr_s;
  logic [DW-1:0]    dq_s;

  sssc_sync #(.W(AW + DW)) u_sync_data (
    .ref_clk_i (ref_clk_i),
    .reset_i   (reset_i),
    .async_i   ({addr_i, dq_i}),
    .sync_o    (data_sync_w)
  );

  // Kept aligned so a taken access sees its own address and data
  assign {addr_s, dq_s} = data_sync_w;

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  function automatic logic is_write(input logic [NL-1:0] lanes, input logic wq_n, input logic gw_n);
    is_write = ((~&lanes) & ~wq_n) | ~gw_n;
  endfunction : is_write

  logic sssc_unused;
  logic any_addr_strobe_n;
  logic enable;
  logic wr_req;
  logic rd_req;
  logic live;

  // Burst order and advance have no effect in the fixed non-burst mode
  assign sssc_unused       = adv_n_s ^ order_s ^ (|spare_s);
  assign any_addr_strobe_n = processor_addr_strobe_n_n_s & controller_addr_strobe_n_n_s;
  assign enable            = ~cs1_n_s & cs2_s & ~cs3_n_s;

  // ----------------------------------------
  // Sleep state machine
  // ----------------------------------------
  sssc_state_t    state_r;
  sssc_state_t    state_nxt;
  logic [CW-1:0]  wake_cnt_r;

  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      SSSC_ST_RUN:   if (slp_s) state_nxt = SSSC_ST_SLEEP;
      SSSC_ST_SLEEP: if (!slp_s) state_nxt = SSSC_ST_WAKE;
      SSSC_ST_WAKE:
      begin
        if (slp_s)
          state_nxt = SSSC_ST_SLEEP;
        else if (wake_cnt_r == CW'(EXIT - 1))
          state_nxt = SSSC_ST_RUN;
      end
      default:       state_nxt = SSSC_ST_RUN;
    endcase
  end

  // State register
  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i)
      state_r <= SSSC_ST_RUN;
    else
      state_r <= state_nxt;
  end

  // Recovery interval counter
  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i || state_r != SSSC_ST_WAKE)
      wake_cnt_r <= '0;
    else
      wake_cnt_r <= wake_cnt_r + CW'(1);
  end

  // Accesses only while running and no sleep pending
  assign live   = (state_r == SSSC_ST_RUN) && !slp_s;
  assign wr_req = live && enable && !any_addr_strobe_n
                  && is_write(lane_n_s, wq_n_s, gw_n_s);
  assign rd_req = live && enable && !any_addr_strobe_n && !wr_req;

  // ----------------------------------------
  // Array and pipelined read path
  // ----------------------------------------
  localparam int LW = DW / NL;
  logic [DW-1:0] rd_word_w;
  logic [AW-1:0] addr_r;
  logic [DW-1:0] rd_data_r;
  logic          rd_pend_r;
  logic          rd_valid_r;
  logic          wr_busy_r;
  logic          sel_r;

  // Fresh external address captured each access
  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i)
      addr_r <= '0;
    else if (!any_addr_strobe_n)
      addr_r <= addr_s;
  end

  // Byte lane writes into the array, one storage bank per lane
  for (genvar g = 0; g < NL; g++)
  begin : g_lane
    logic [LW-1:0] lane_mem_r [2**AW];

    // Lane bank written only when its lane or global write is active
    always_ff @(posedge ref_clk_i)
    begin
      if (wr_req && (!gw_n_s || !lane_n_s[g]))
        lane_mem_r[addr_s] <= dq_s[g*LW +: LW];
    end

    // Lane slice of the read word
    assign rd_word_w[g*LW +: LW] = lane_mem_r[addr_r];
  end

  // Read pipeline stages
  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i)
    begin
      rd_pend_r  <= 1'b0;
      rd_valid_r <= 1'b0;
      rd_data_r  <= '0;
    end
    else
    begin
      rd_pend_r  <= rd_req;
      rd_valid_r <= rd_pend_r && live;
      if (rd_pend_r)
        rd_data_r <= rd_word_w;
    end
  end

  // Write in progress masks output drive
  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i)
      wr_busy_r <= 1'b0;
    else
      wr_busy_r <= wr_req;
  end

  // Selected flag, cleared in sleep
  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i)
      sel_r <= 1'b0;
    else if (!live)
      sel_r <= 1'b0;
    else if (!any_addr_strobe_n)
      sel_r <= enable;
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign dq_o            = rd_data_r;
  assign dq_oe_o         = rd_valid_r && live && !wr_busy_r && !wr_req && !oe_n_s;
  assign asleep_o        = (state_r == SSSC_ST_SLEEP);
  assign selected_o      = sel_r;
  assign unsafe_window_o = !live && (state_r != SSSC_ST_SLEEP);
endmodule : sssc_ctrl

// file: hw/sssc_pkg.sv
// Types for the sync SRAM sleep and access sequencer
package sssc_pkg;
  typedef enum logic [1:0] {
    SSSC_ST_RUN   = 2'b00,
    SSSC_ST_SLEEP = 2'b01,
    SSSC_ST_WAKE  = 2'b10
  } sssc_state_t;
endpackage : sssc_pkg

// file: hw/sssc_sync.sv
// Two flip-flop synchroniser bank
`timescale 1ns/1ps
module sssc_sync #(
  parameter int W = 1
) (
  input  wire logic         ref_clk_i,
  input  wire logic         reset_i,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);
  logic [W-1:0] meta_r;

  // First stage feeds only the second
  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i)
    begin
      meta_r <= '0;
      sync_o <= '0;
    end
    else
    begin
      meta_r <= async_i;
      sync_o <= meta_r;
    end
  end
endmodule : sssc_sync

// file: test/sssc_ctrl_assertions.sv
// Port checker for the sync SRAM sequencer
`timescale 1ns/1ps
module sssc_ctrl_checker (
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic sleep_request_i,
  input wire logic out_drive_n_i,
  input wire logic chip_sel_first_n_i,
  input wire logic chip_sel_second_i,
  input wire logic chip_sel_third_n_i,
  input wire logic dq_oe_o,
  input wire logic asleep_o,
  input wire logic selected_o,
  input wire logic unsafe_window_o
);
  logic en;
  // Chip enable decode
  assign en = !chip_sel_first_n_i && chip_sel_second_i && !chip_sel_third_n_i;
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (reset_i);
  a_sleep_no_drive: assert property (asleep_o |-> !dq_oe_o) else $error("drive in sleep");
  a_sleep_unselected: assert property (asleep_o |-> !selected_o) else $error("select in sleep");
  a_sleep_entry: assert property ($rose(sleep_request_i) |-> ##[1:4] asleep_o) else $error("late sleep");
  a_wake_bound: assert property ($fell(sleep_request_i) |-> ##[2:8] !unsafe_window_o && !asleep_o)
    else $error("late wake");
  a_drive_gate: assert property (dq_oe_o |-> !$past(out_drive_n_i, 2)) else $error("drive not asked");
  a_select_decode: assert property ($rose(selected_o) |-> $past(en, 3)) else $error("bad select");
  a_unsafe_req: assert property (sleep_request_i && $past(sleep_request_i, 3) |-> unsafe_window_o || asleep_o)
    else $error("no unsafe flag");
  a_asleep_cause: assert property ($rose(asleep_o) |-> $past(sleep_request_i, 2)) else $error("sleep cause");
  c_sleep: cover property ($rose(asleep_o));
  c_read: cover property ($rose(dq_oe_o));
  c_wake: cover property ($fell(sleep_request_i) ##5 !unsafe_window_o && !asleep_o);
endmodule : sssc_ctrl_checker
bind sssc_ctrl sssc_ctrl_checker u_chk (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .sleep_request_i(sleep_request_i),
  .out_drive_n_i(out_drive_n_i), .chip_sel_first_n_i(chip_sel_first_n_i), .chip_sel_second_i(chip_sel_second_i),
  .chip_sel_third_n_i(chip_sel_third_n_i), .dq_oe_o(dq_oe_o), .asleep_o(asleep_o), .selected_o(selected_o),
  .unsafe_window_o(unsafe_window_o));

// file: test/sssc_ctrl_tb.sv
// Self-checking bench for the sync SRAM sequencer
`timescale 1ns/1ps
module sssc_ctrl_tb;
  logic        ref_clk_i = 1'b0, reset_i = 1'b1, oe_q = 1'b0;
  logic        dq_oe_o, asleep_o, selected_o, unsafe_window_o;
  logic [31:0] dq_o, mem_v, rnd = 32'h2F7E;
  logic [31:0] exp_q[$];
  int          num_errors = 0, checks_done = 0;
  sssc_host_model host (.ref_clk_i(ref_clk_i));
  sssc_ctrl uut (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .sleep_request_i(host.sleep_r),
    .processor_addr_strobe_n_i(host.pstb_n_r), .controller_addr_strobe_n_i(host.cstb_n_r),
    .burst_advance_n_i(1'b1), .chip_sel_first_n_i(host.sel1_n_r), .chip_sel_second_i(host.sel2_r),
    .chip_sel_third_n_i(host.sel3_n_r), .burst_order_select_i(1'b0), .byte_lane_write_n_i(host.lane_n_r),
    .write_qualifier_n_i(host.qual_n_r), .global_write_n_i(host.gw_n_r), .out_drive_n_i(host.drv_n_r),
    .addr_i(host.addr_r), .dq_i(host.wdat_r), .dq_o(dq_o), .dq_oe_o(dq_oe_o), .asleep_o(asleep_o),
    .selected_o(selected_o), .unsafe_window_o(unsafe_window_o));
  initial forever #12.5 ref_clk_i = ~ref_clk_i;
  function automatic logic [31:0] xs(input logic [31:0] v);
    v = v ^ (v << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction : xs
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    checks_done++;
    if (seen !== want)
    begin
      num_errors++;
      $display("[ERR] %0t seen %h want %h", $time, seen, want);
    end
  endtask : check
  task automatic close_out;
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : close_out
  // Read with or without a noted result
  task automatic rd(input logic proc, input logic [15:0] a, input logic noted);
    if (noted)
      exp_q.push_back(mem_v);
    host.access(proc, 4'hF, 1'b1, a, 32'h0);
  endtask : rd
  // Oldest note against each new read result
  always @(posedge ref_clk_i)
  begin
    oe_q <= dq_oe_o;
    if (!reset_i && dq_oe_o === 1'b1 && oe_q !== 1'b1)
      check(dq_o, exp_q.size() > 0 ? exp_q.pop_front() : ~dq_o ^ 32'h1);
  end
  // Scenario sequence
  initial
  begin
    int          n;
    logic [15:0] a;
    repeat (20) @(posedge ref_clk_i);
    reset_i <= 1'b0;
    repeat (3) @(posedge ref_clk_i);
    rnd = xs(rnd);
    a = rnd[15:0];
    mem_v = xs(rnd);
    host.access(1'b0, 4'hF, 1'b0, a, mem_v);
    rd(1'b0, a, 1'b1);
    for (n = 0; n < 4; n++)
    begin
      rnd = xs(rnd);
      host.access(1'b0, ~(4'h1 << n), 1'b1, a, rnd);
      mem_v[8*n +: 8] = rnd[8*n +: 8];
      rd(n[0], a, 1'b1);
    end
    for (n = 0; n < 3; n++)
    begin
      {host.sel1_n_r, host.sel2_r, host.sel3_n_r} <= 3'b010 ^ (3'b001 << n);
      rd(1'b0, a, 1'b0);
    end
    check({31'h0, selected_o}, 32'h0);
    {host.sel1_n_r, host.sel2_r, host.sel3_n_r} <= 3'b010;
    host.sleep_on();
    for (n = 0; n < 8 && asleep_o !== 1'b1; n++) @(posedge ref_clk_i);
    check({31'h0, asleep_o}, 32'h1);
    if (n == 8) close_out();
    check({31'h0, selected_o}, 32'h0);
    rd(1'b0, a, 1'b0);
    host.sleep_off();
    check({31'h0, unsafe_window_o}, 32'h1);
    for (n = 0; n < 8 && unsafe_window_o !== 1'b0; n++) @(posedge ref_clk_i);
    check({31'h0, unsafe_window_o}, 32'h0);
    check({31'h0, asleep_o}, 32'h0);
    if (n == 8) close_out();
    rd(1'b0, a, 1'b1);
    repeat (10) @(posedge ref_clk_i);
    check(32'(exp_q.size()), 32'h0);
    check({31'h0, selected_o}, 32'h1);
    close_out();
  end
endmodule : sssc_ctrl_tb

// file: test/sssc_host_model.sv
// Behavioural cache controller driving the sequencer pins
`timescale 1ns/1ps
module sssc_host_model (
  input wire logic ref_clk_i
);
  logic        sleep_r = 1'b0, pstb_n_r = 1'b1, cstb_n_r = 1'b1, qual_n_r = 1'b1, gw_n_r = 1'b1;
  logic        sel1_n_r = 1'b0, sel2_r = 1'b1, sel3_n_r = 1'b0, drv_n_r = 1'b1;
  logic [3:0]  lane_n_r = 4'hF;
  logic [15:0] addr_r = 16'h0;
  logic [31:0] wdat_r = 32'h0;
  // One access, then strobes idle and lines show inverted values
  task automatic access(input logic proc, input logic [3:0] lane_n, input logic gw_n,
                        input logic [15:0] a, input logic [31:0] d);
    drv_n_r <= ~gw_n | ~&lane_n;
    @(posedge ref_clk_i);
    pstb_n_r <= ~proc;
    cstb_n_r <= proc;
    lane_n_r <= lane_n;
    qual_n_r <= &lane_n;
    gw_n_r <= gw_n;
    addr_r <= a;
    wdat_r <= d;
    @(posedge ref_clk_i);
    pstb_n_r <= 1'b1;
    cstb_n_r <= 1'b1;
    lane_n_r <= 4'hF;
    qual_n_r <= 1'b1;
    gw_n_r <= 1'b1;
    addr_r <= ~a;
    wdat_r <= ~d;
    repeat (4) @(posedge ref_clk_i);
    drv_n_r <= 1'b1;
    @(posedge ref_clk_i); // Next call starts on a later edge
  endtask : access
  // Quiet cycles before the request
  task automatic sleep_on;
    repeat (2) @(posedge ref_clk_i);
    sleep_r <= 1'b1;
  endtask : sleep_on
  // Release, then stay quiet for four cycles, returning while recovery is still running
  task automatic sleep_off;
    sleep_r <= 1'b0;
    repeat (4) @(posedge ref_clk_i);
  endtask : sleep_off
endmodule : sssc_host_model
